// file: timer_prescaler_sync_unit_bench.sv
// Self-checking bench for the timer prescaler and synchronisation unit
`timescale 1ns/1ps
module timer_prescaler_sync_unit_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic en = 1'b1;
   logic psel, penable, pwrite, async_a, pready, pslverr, err, pin, done, pb, pa, hb, ha;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, s1;
   int n_mismatch = 0;
   int checks = 0;
   int c0, a0, d, e;
   int sh[6] = '{0, 0, 3, 6, 8, 10};
   always #5 pclk = ~pclk;
   tpsu_top tpsu_top_i (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_count_pin(pin), .timer_a_async(async_a),
      .timer_a_clear_done(done), .timer_b_count_pulse(pb), .timer_a_count_pulse(pa),
      .timer_b_halt(hb), .timer_a_halt(ha));
   tpsu_far_side tpsu_far_side_i (.pclk(pclk), .presetn(presetn), .pulse_b(pb), .pulse_a(pa),
      .halt_a(ha), .pin(pin), .clear_done(done));
   // ==========================================================
   // Shared tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Caller enters just after a rising edge; one idle edge follows each transfer
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // ==========================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, async_a} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h7c);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h01);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h83);
      chk({30'h0, ha, hb}, 32'h3);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h83);
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h00);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h02);
      apb(1'b0, tpsu_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      s1 = rd;
      apb(1'b1, tpsu_pkg::ADDR_TIMER_B_SRC, 32'(tpsu_pkg::SRC_DIV8));
      apb(1'b0, tpsu_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[9:0] - s1[9:0]), 32'h6);
      $display("test control register done");
      // Both timers released together from hold, so their counts must agree
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, tpsu_pkg::ADDR_TIMER_B_SRC, 32'(c));
         apb(1'b1, tpsu_pkg::ADDR_TIMER_A_SRC, 32'(c));
         apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h83);
         apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h00);
         c0 = tpsu_far_side_i.cnt_b;
         a0 = tpsu_far_side_i.cnt_a;
         repeat (2048) @(posedge pclk);
         d = tpsu_far_side_i.cnt_b - c0;
         e = (c == 0) ? 0 : (2048 >> sh[c]);
         chk({31'h0, d >= e - 1 && d <= e + int'(c > 0)}, 32'h1);
         chk(32'(tpsu_far_side_i.cnt_a - a0), 32'(d));
      end
      $display("test internal sources done");
      for (int c = 7; c >= 6; c--) begin
         apb(1'b1, tpsu_pkg::ADDR_TIMER_B_SRC, 32'(c));
         c0 = tpsu_far_side_i.cnt_b;
         tpsu_far_side_i.toggle(10, 3);
         repeat (8) @(posedge pclk);
         chk(32'(tpsu_far_side_i.cnt_b - c0), 32'h5);
      end
      $display("test pin source done");
      async_a <= 1'b1;
      apb(1'b1, tpsu_pkg::ADDR_SYNC_CTRL, 32'h02);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h02);
      repeat (12) @(posedge pclk);
      apb(1'b0, tpsu_pkg::ADDR_SYNC_CTRL, 32'h0);
      chk(rd, 32'h0);
      $display("test asynchronous clear done");
      // Enable low for 20 edges: only the three enabled edges advance the divider
      apb(1'b0, tpsu_pkg::ADDR_STATUS, 32'h0);
      s1 = rd;
      en <= 1'b0;
      repeat (20) @(posedge pclk);
      en <= 1'b1;
      apb(1'b0, tpsu_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[9:0] - s1[9:0]), 32'h3);
      $display("test clock enable done");
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge pclk);
      n_mismatch++;
      stop_test();
   end
endmodule : timer_prescaler_sync_unit_bench

// file: tpsu_far_side.sv
// Far-side model: external count pin source and the two timers' pulse counters
`timescale 1ns/1ps
module tpsu_far_side (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // From the prescaler unit
   input wire logic pulse_b,
   input wire logic pulse_a,
   input wire logic halt_a,
   // To the prescaler unit
   output logic pin,
   output logic clear_done
);
   // ==========================================================
   // Timer pulse counters and slow-domain clear handshake
   int cnt_b;
   int cnt_a;
   int wait_r;
   initial pin = 1'b0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_b <= 0;
         cnt_a <= 0;
         wait_r <= 0;
      end else begin
         cnt_b <= cnt_b + int'(pulse_b);
         cnt_a <= cnt_a + int'(pulse_a);
         wait_r <= halt_a ? wait_r + 1 : 0;
      end
   end
   // The slow timer domain needs several cycles before it reports done
   assign clear_done = (wait_r >= 8);
   // ==========================================================
   // Pin moves just after an edge, each level held hp cycles
   task automatic toggle(input int n, input int hp);
      repeat (n) begin
         repeat (hp) @(posedge pclk);
         pin <= ~pin;
      end
   endtask : toggle
endmodule : tpsu_far_side

// file: tpsu_pkg.sv
// Package for the timer prescaler and synchronisation unit
package tpsu_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_SYNC_CTRL = 12'h000;
   localparam logic [11:0] ADDR_TIMER_B_SRC = 12'h004;
   localparam logic [11:0] ADDR_TIMER_A_SRC = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;
   // ==========================================================
   // Control register fields
   localparam int BIT_CLR_B = 0;
   localparam int BIT_CLR_A = 1;
   localparam int BIT_HOLD = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h83;
   // ==========================================================
   // Count source select codes
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_DIRECT = 3'h1;
   localparam logic [2:0] SRC_DIV8 = 3'h2;
   localparam logic [2:0] SRC_DIV64 = 3'h3;
   localparam logic [2:0] SRC_DIV256 = 3'h4;
   localparam logic [2:0] SRC_DIV1024 = 3'h5;
   localparam logic [2:0] SRC_PIN_FALL = 3'h6;
   localparam logic [2:0] SRC_PIN_RISE = 3'h7;
   // ==========================================================
   // Divider
   localparam int DIV_WIDTH = 10;
   localparam logic [9:0] TAP8_MASK = 10'h007;
   localparam logic [9:0] TAP64_MASK = 10'h03f;
   localparam logic [9:0] TAP256_MASK = 10'h0ff;
   localparam logic [9:0] TAP1024_MASK = 10'h3ff;
   localparam logic [9:0] DIV_RESET = 10'h000;
endpackage : tpsu_pkg

// file: tpsu_top.sv
// Shared timer prescaler, external count pin sampling and sync control
//
// Function
// - Provide undivided clock plus divide by 8, 64, 256 and 1024 sources.
// - Divider runs freely; source selection never restarts it.
// - First divided pulse comes 1 to N cycles after enabling.
// - A divider reset restarts the period for every attached timer.
// - Pin sampled every cycle through synchroniser, then edge detected.
// - Sampling on rising edge with a latch transparent in clock high.
// - Select 7 counts rising pin edges, select 6 falling edges.
// - Pin edge reaches the count pulse output 2 to 3 cycles later.
// - Pin pulses bypass the divider entirely.
// - Hold bit 7 keeps both clear bits set, halting the timers.
// - Clearing the hold bit clears both clear bits in hardware, bit 1 in async mode only once done.
// - Clear bit 0 resets timer B divider, self clears unless held.
// - Clear bit 1 resets timer A divider; stays set until async done.
// - Select 0 gives no count pulses.
`timescale 1ns/1ps
module tpsu_top (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External count pin
   input wire logic external_count_pin,
   // Timer A asynchronous mode and its divider-reset completion
   input wire logic timer_a_async,
   input wire logic timer_a_clear_done,
   // Count pulses to the timers
   output logic timer_b_count_pulse,
   output logic timer_a_count_pulse,
   // Divider reset levels to the timers
   output logic timer_b_halt,
   output logic timer_a_halt
);
   // ==========================================================
   // Select decode, shared by both timers
   function automatic logic pick_pulse(input logic [2:0] sel, input logic [9:0] cnt,
                                       input logic rise, input logic fall);
      case (sel)
         tpsu_pkg::SRC_NONE: pick_pulse = 1'b0;
         tpsu_pkg::SRC_DIRECT: pick_pulse = 1'b1;
         tpsu_pkg::SRC_DIV8: pick_pulse = ((cnt & tpsu_pkg::TAP8_MASK) == tpsu_pkg::TAP8_MASK);
         tpsu_pkg::SRC_DIV64: pick_pulse = ((cnt & tpsu_pkg::TAP64_MASK) == tpsu_pkg::TAP64_MASK);
         tpsu_pkg::SRC_DIV256: pick_pulse = ((cnt & tpsu_pkg::TAP256_MASK) == tpsu_pkg::TAP256_MASK);
         tpsu_pkg::SRC_DIV1024: pick_pulse = (cnt == tpsu_pkg::TAP1024_MASK);
         tpsu_pkg::SRC_PIN_FALL: pick_pulse = fall;
         tpsu_pkg::SRC_PIN_RISE: pick_pulse = rise;
         default: pick_pulse = 1'b0;
      endcase
   endfunction : pick_pulse

   // ==========================================================
   // State
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [2:0] src_b_r, src_b_nxt;
   logic [2:0] src_a_r, src_a_nxt;
   logic [9:0] div_b_r, div_b_nxt;
   logic [9:0] div_a_r, div_a_nxt;
   logic [2:0] pin_r, pin_nxt;
   logic pin_latch;
   logic pulse_b_r, pulse_b_nxt;
   logic pulse_a_r, pulse_a_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic edge_rise;
   logic edge_fall;

   assign wr_en = psel & penable & pwrite & clk_en;
   assign rd_en = psel & ~penable & ~pwrite;
   assign mapped = (paddr == tpsu_pkg::ADDR_SYNC_CTRL) || (paddr == tpsu_pkg::ADDR_TIMER_B_SRC) ||
                   (paddr == tpsu_pkg::ADDR_TIMER_A_SRC) || (paddr == tpsu_pkg::ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = rdata_r;

   // ==========================================================
   // Pin synchroniser: two flops, then a half-cycle latch
   // Latch is transparent in clock high, so it adds no half cycle; the delay is 2 to 3 cycles
   always_latch begin
      if (pclk) begin
         pin_latch = pin_r[1];
      end
   end

   always_comb begin
      pin_nxt = {pin_latch, pin_r[1], pin_r[0]};
      pin_nxt[0] = external_count_pin;
      pin_nxt[1] = pin_r[0];
      pin_nxt[2] = pin_latch;
   end

   // Only the latched and delayed stages feed the detector
   assign edge_rise = pin_latch & ~pin_r[2];
   assign edge_fall = ~pin_latch & pin_r[2];

   // ==========================================================
   // Control register and source selects
   always_comb begin
      ctrl_nxt = ctrl_r;
      src_b_nxt = src_b_r;
      src_a_nxt = src_a_r;
      if (wr_en && paddr == tpsu_pkg::ADDR_SYNC_CTRL) begin
         ctrl_nxt = pwdata[7:0] & tpsu_pkg::CTRL_MASK;
      end else begin
         if (!ctrl_r[tpsu_pkg::BIT_HOLD]) begin
            // Hold low: clear bit B self clears after one cycle, clear bit A too unless async and not done
            ctrl_nxt[tpsu_pkg::BIT_CLR_B] = 1'b0;
            if (!(timer_a_async && !timer_a_clear_done)) begin
               ctrl_nxt[tpsu_pkg::BIT_CLR_A] = 1'b0;
            end
         end
      end
      if (wr_en && paddr == tpsu_pkg::ADDR_TIMER_B_SRC) begin
         src_b_nxt = pwdata[2:0];
      end
      if (wr_en && paddr == tpsu_pkg::ADDR_TIMER_A_SRC) begin
         src_a_nxt = pwdata[2:0];
      end
   end

   // Hold bit set: written clear bits stay, keeping the timers halted
   assign timer_b_halt = ctrl_r[tpsu_pkg::BIT_CLR_B];
   assign timer_a_halt = ctrl_r[tpsu_pkg::BIT_CLR_A];

   // ==========================================================
   // Dividers: free running, restarted only by a clear bit, either one
   // Both dividers act as one shared prescaler: either clear restarts both
   always_comb begin
      div_b_nxt = div_b_r + 10'h001;
      div_a_nxt = div_a_r + 10'h001;
      if (ctrl_r[tpsu_pkg::BIT_CLR_B] || ctrl_r[tpsu_pkg::BIT_CLR_A]) begin
         div_b_nxt = tpsu_pkg::DIV_RESET;
         div_a_nxt = tpsu_pkg::DIV_RESET;
      end
   end

   // ==========================================================
   // Count pulses, registered; halted timers get none
   always_comb begin
      pulse_b_nxt = 1'b0;
      pulse_a_nxt = 1'b0;
      if (!ctrl_r[tpsu_pkg::BIT_CLR_B]) begin
         pulse_b_nxt = pick_pulse(src_b_r, div_b_r, edge_rise, edge_fall);
      end
      if (!ctrl_r[tpsu_pkg::BIT_CLR_A]) begin
         pulse_a_nxt = pick_pulse(src_a_r, div_a_r, edge_rise, edge_fall);
      end
   end

   assign timer_b_count_pulse = pulse_b_r;
   assign timer_a_count_pulse = pulse_a_r;

   // ==========================================================
   // Read data, captured in the setup cycle
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_en) begin
         case (paddr)
            tpsu_pkg::ADDR_SYNC_CTRL: rdata_nxt = {24'h000000, ctrl_r};
            tpsu_pkg::ADDR_TIMER_B_SRC: rdata_nxt = {29'h00000000, src_b_r};
            tpsu_pkg::ADDR_TIMER_A_SRC: rdata_nxt = {29'h00000000, src_a_r};
            tpsu_pkg::ADDR_STATUS: rdata_nxt = {12'h000, div_a_r, div_b_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tpsu_pkg::CTRL_RESET;
         src_b_r <= tpsu_pkg::SRC_NONE;
         src_a_r <= tpsu_pkg::SRC_NONE;
         div_b_r <= tpsu_pkg::DIV_RESET;
         div_a_r <= tpsu_pkg::DIV_RESET;
         pin_r <= 3'h0;
         pulse_b_r <= 1'b0;
         pulse_a_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else if (clk_en) begin
         ctrl_r <= ctrl_nxt;
         src_b_r <= src_b_nxt;
         src_a_r <= src_a_nxt;
         div_b_r <= div_b_nxt;
         div_a_r <= div_a_nxt;
         pin_r <= pin_nxt;
         pulse_b_r <= pulse_b_nxt;
         pulse_a_r <= pulse_a_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Assertions
   // Control register and clear bits
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[6:2] == 5'h00) else $error("reserved control bits set");
   a_hold_keeps_b: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[7] && ctrl_r[0] && !wr_en) |=> ctrl_r[0])
      else $error("clear bit dropped while held");
   a_release_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !ctrl_r[7] && !wr_en && !timer_a_async) |=> ctrl_r[1:0] == 2'h0)
      else $error("clear bits not cleared with hold low");
   a_clear_b_once: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[0] && !ctrl_r[7] && !wr_en) |=> !ctrl_r[0])
      else $error("timer b clear bit did not self clear");
   a_async_stays: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[1] && timer_a_async && !timer_a_clear_done && !wr_en) |=> ctrl_r[1])
      else $error("timer a clear bit left early");
   a_hold_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_HOLD] && ctrl_r[tpsu_pkg::BIT_CLR_A] && !wr_en)
      |=> ctrl_r[tpsu_pkg::BIT_CLR_A]) else $error("timer a clear bit dropped while held");
   a_clear_a_once: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_CLR_A] && !ctrl_r[tpsu_pkg::BIT_HOLD] && !wr_en
      && !timer_a_async) |=> !ctrl_r[tpsu_pkg::BIT_CLR_A]) else $error("clear a stuck");
   a_async_done: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_CLR_A] && !ctrl_r[tpsu_pkg::BIT_HOLD] && !wr_en
      && timer_a_clear_done) |=> !ctrl_r[tpsu_pkg::BIT_CLR_A]) else $error("clear a kept");
   a_write_masked: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == tpsu_pkg::ADDR_SYNC_CTRL) |=>
      ctrl_r == ($past(pwdata[7:0]) & tpsu_pkg::CTRL_MASK)) else $error("control write lost");
   a_halt_b_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_CLR_B]) |=> !timer_b_count_pulse)
      else $error("halted timer b got a pulse");
   a_halt_a_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_CLR_A]) |=> !timer_a_count_pulse)
      else $error("halted timer a got a pulse");

   // Shared divider and clock enable
   // Freeze checks guard against a register that ignores the enable
   a_div_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[1]) |=> div_b_r == 10'h000)
      else $error("timer a clear did not restart shared divider");
   a_clear_b_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r[tpsu_pkg::BIT_CLR_B]) |=> div_a_r == tpsu_pkg::DIV_RESET)
      else $error("timer b clear did not restart shared divider");
   a_div_free: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !ctrl_r[tpsu_pkg::BIT_CLR_B] && !ctrl_r[tpsu_pkg::BIT_CLR_A]) |=>
      div_b_r == $past(div_b_r) + 10'h001) else $error("divider did not advance");
   a_freeze_div: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(div_b_r))
      else $error("divider moved with enable low");
   a_freeze_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(ctrl_r))
      else $error("control moved with enable low");

   // Source selection
   a_none_silent: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == 3'h0) |=> !timer_b_count_pulse)
      else $error("pulse with no source");
   a_none_silent_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_a_r == tpsu_pkg::SRC_NONE) |=> !timer_a_count_pulse)
      else $error("timer a pulse with no source");
   a_direct_runs: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == 3'h1 && !ctrl_r[0]) |=> timer_b_count_pulse)
      else $error("direct source missed a cycle");
   a_direct_runs_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_a_r == tpsu_pkg::SRC_DIRECT && !ctrl_r[tpsu_pkg::BIT_CLR_A])
      |=> timer_a_count_pulse) else $error("timer a direct source missed a cycle");
   a_div8_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == 3'h2 && !ctrl_r[0] && div_b_r[2:0] != 3'h7) |=> !timer_b_count_pulse)
      else $error("divide by 8 pulse out of phase");
   a_div8_fires: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_DIV8 && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      (div_b_r & tpsu_pkg::TAP8_MASK) == tpsu_pkg::TAP8_MASK) |=> timer_b_count_pulse);
   a_div64_phase: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_DIV64 && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      (div_b_r & tpsu_pkg::TAP64_MASK) != tpsu_pkg::TAP64_MASK) |=> !timer_b_count_pulse);
   a_div256_phase: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_DIV256 && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      (div_b_r & tpsu_pkg::TAP256_MASK) != tpsu_pkg::TAP256_MASK) |=> !timer_b_count_pulse);
   a_div1024_phase: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_DIV1024 && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      div_b_r != tpsu_pkg::TAP1024_MASK) |=> !timer_b_count_pulse);

   // Pin path
   a_sync_chain: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en |=> pin_r[1] == $past(pin_r[0]))
      else $error("synchroniser stage skipped");
   a_detect_stage: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en |=> pin_r[2] == $past(pin_latch))
      else $error("detector stage skipped");
   a_pin_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_PIN_RISE && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      edge_rise) |=> timer_b_count_pulse) else $error("rising pin edge lost");
   a_pin_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_PIN_FALL && !ctrl_r[tpsu_pkg::BIT_CLR_B] &&
      edge_fall) |=> timer_b_count_pulse) else $error("falling pin edge lost");
   a_pin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && src_b_r == tpsu_pkg::SRC_PIN_RISE && !edge_rise) |=> !timer_b_count_pulse)
      else $error("pin source pulsed without an edge");
endmodule : tpsu_top
